/* sps_pkg.sv */
// package: constants, types and contract list of the serial port block
// Contract
// - Modes 2/3 with address filter: receive flag needs ninth bit 1 and address match.
// - Mode 1 with address filter: receive flag needs valid stop bit and address match.
// - Reception runs only while receive enable is set.
// - Modes 2/3 send the software ninth bit as ninth data bit.
// - Received ninth bit holds ninth bit, or mode 1 stop bit without filter.
// - Transmit flag set after eighth bit in mode 0, else at stop start.
// - Receive flag set after eighth bit in mode 0, else mid stop bit.
// - Mode 0 bit rate is oscillator divided by two.
// - Mode 2 bit rate is oscillator /32, or /16 with baud doubler.
// - Modes 1/3 bit rate is timer overflow rate times 2^doubler over 32.
// - 8-bit reload timer overflows every 256 minus reload clocks.
// - 16-bit reload timer overflows every 65536 minus reload clocks.
// - Mode 0 moves eight bits LSB first on data pin, clock on other pin.
// - Mode 0 buffer write loads a 1 above the byte; drive starts one cycle later.
// - Mode 0 transmit drives data and clock pins, shifting right each falling edge.
// - Zeros enter left; marker beside MSB causes last shift, stop, transmit flag.
// - Mode 0 enable with flag clear loads 1111110 then starts receive stage; the code loads 11111110 (RX0_PRELOAD).
// - Mode 0 receive drives clock, shifts left, new bit sampled at rising edge.
// - Preloaded 0 reaching the left causes last shift, buffer load, receive flag.
// - Mode 1 frame: start 0, eight data bits LSB first, stop 1.
// - Modes 2/3 frame: start 0, eight data bits, ninth bit, stop 1.
// - Modes 1-3 reception begins at a start bit, only with receive enable.
// - Top control bit is framing error when selected, else mode bit; software clears.
package sps_pkg;
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  OFF_SCTRL    = 8'h00;
	localparam logic [7:0]  OFF_BUF      = 8'h04;
	localparam logic [7:0]  OFF_PWR      = 8'h08;
	localparam logic [7:0]  OFF_TIMER_MODE_REGISTER     = 8'h0C;
	localparam logic [7:0]  OFF_RLD8     = 8'h10;
	localparam logic [7:0]  OFF_RLD16    = 8'h14;
	localparam logic [7:0]  OFF_ADDR     = 8'h18;
	localparam logic [7:0]  SERIAL_CONTROL_RESET   = 8'h00;
	localparam int          PWR_DBL_BIT  = 7;
	localparam int          PWR_FSE_BIT  = 6;
	localparam logic [1:0]  MODE0        = 2'h0;
	localparam logic [1:0]  MODE1        = 2'h1;
	localparam logic [1:0]  MODE2        = 2'h2;
	localparam logic [1:0]  T1_MODE_16   = 2'h1;
	localparam logic [1:0]  T1_MODE_8    = 2'h2;
	localparam logic [7:0]  T1_MAX8      = 8'hFF;
	localparam logic [15:0] T1_MAX16     = 16'hFFFF;
	localparam logic [3:0]  DIV_LAST     = 4'hF;
	localparam logic [3:0]  SMP_A        = 4'h7;
	localparam logic [3:0]  SMP_B        = 4'h8;
	localparam logic [3:0]  SMP_C        = 4'h9;
	localparam logic [3:0]  IDX_NINTH    = 4'h9;
	localparam logic [3:0]  IDX_STOP1    = 4'h9;
	localparam logic [3:0]  IDX_STOP23   = 4'hA;
	localparam logic [7:0]  TX0_MARK     = 8'h01;
	localparam logic [7:0]  RX0_PRELOAD  = 8'hFE;
	localparam int          MC_CLKS      = 1;
	localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
	typedef struct packed {
		logic mode_bit_high;
		logic mode_bit_low;
		logic address_filter_enable;
		logic receive_enable;
		logic transmit_ninth_bit;
		logic received_ninth_bit;
		logic transmit_flag;
		logic receive_flag;
	} sps_serial_control_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              write;
		logic              valid;
	} sps_ahb_req_t;
	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_SEND = 2'b11} sps_tx_st_t;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00, RX_LOAD0 = 2'b01, RX_SHIFT0 = 2'b11, RX_ASYNC = 2'b10
	} sps_rx_st_t;
endpackage

/* sps_serial_port.sv */
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// serial port: control register, four modes, bit-rate timer and mode 0 shift logic
module sps_serial_port #(
	parameter int MC_DELAY = sps_pkg::MC_CLKS
) (
	input  logic        clk,
	input  logic        rst_n,
	input  logic        ce,
	input  logic        hsel,
	input  logic [31:0] haddr,
	input  logic [1:0]  htrans,
	input  logic        hwrite,
	input  logic [2:0]  hsize,
	input  logic [31:0] hwdata,
	input  logic        hready,
	output logic        hreadyout,
	output logic        hresp,
	output logic [31:0] hrdata,
	input  logic        port_line_data_in,
	output logic        port_line_data_out,
	output logic        port_line_data_oe,
	output logic        port_line_clock_out
);
	import sps_pkg::*;

	sps_serial_control_t    serial_control;
	sps_ahb_req_t req;
	sps_tx_st_t   tx_st;
	sps_rx_st_t   rx_st;
	logic         framing_error;
	logic         baud_doubler;
	logic         frame_error_select;
	logic [3:0]   timer_mode;
	logic [7:0]   timer_high_reload;
	logic [15:0]  reload16;
	logic [7:0]   given_addr;
	logic [7:0]   bcast_addr;
	logic [7:0]   rbuf;
	logic         rxd_meta;
	logic         rxd;
	logic         rxd_prev;
	logic [1:0]   mode;
	logic         wr_en;
	logic         wr_buf;
	logic [31:0]  rd_mux;
	logic [15:0]  t1cnt;
	logic         t1_ovf;
	logic         osc_half;
	logic         ovf_half;
	logic         tick16;
	logic [3:0]   tx_div;
	logic         bit_tick;
	logic [8:0]   tx_sh;
	logic [3:0]   tx_idx;
	logic [3:0]   tx_cnt;
	logic [3:0]   tx_stop;
	logic         tx_line;
	logic         ti_set_q;
	logic         ph;
	logic         m0_busy;
	logic [7:0]   rx_sh;
	logic         rx_bit;
	logic         rx_skip;
	logic [3:0]   rx_div;
	logic [3:0]   rx_idx;
	logic [1:0]   vote;
	logic         maj;
	logic         rx_ninth;
	logic         addr_ok;
	logic         ri_set_q;
	logic         fe_set_q;
	logic         rb8_load_q;
	logic         rb8_val_q;

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7-i];
		end
		return r;
	endfunction

	// two-flop synchroniser on the data pin, plus edge history
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxd_meta <= 1'b1;
			rxd      <= 1'b1;
			rxd_prev <= 1'b1;
		end else if (ce) begin
			rxd_meta <= port_line_data_in;
			rxd      <= rxd_meta;
			rxd_prev <= rxd;
		end
	end

	// bus slave: zero wait states, always okay, stalls while ce is low
	assign hreadyout = ce;
	assign hresp     = 1'b0;
	assign wr_en     = req.valid && req.write && ce;
	assign wr_buf    = wr_en && (req.addr == OFF_BUF);

	// capture the address phase
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			req <= '0;
		end else if (ce && hready) begin
			req.valid <= hsel && (htrans == HTRANS_NSEQ);
			req.write <= hwrite;
			req.addr  <= haddr[ADDR_W-1:0];
		end
	end

	// read decode on the address phase
	always_comb begin
		rd_mux = '0;
		if (haddr[ADDR_W-1:0] == OFF_SCTRL) begin
			rd_mux[7:0] = {frame_error_select ? framing_error : serial_control.mode_bit_high, 7'(serial_control)};
		end else if (haddr[ADDR_W-1:0] == OFF_BUF) begin
			rd_mux[7:0] = rbuf;
		end else if (haddr[ADDR_W-1:0] == OFF_PWR) begin
			rd_mux[PWR_DBL_BIT] = baud_doubler;
			rd_mux[PWR_FSE_BIT] = frame_error_select;
		end else if (haddr[ADDR_W-1:0] == OFF_TIMER_MODE_REGISTER) begin
			rd_mux[7:4] = timer_mode;
		end else if (haddr[ADDR_W-1:0] == OFF_RLD8) begin
			rd_mux[7:0] = timer_high_reload;
		end else if (haddr[ADDR_W-1:0] == OFF_RLD16) begin
			rd_mux[15:0] = reload16;
		end else if (haddr[ADDR_W-1:0] == OFF_ADDR) begin
			rd_mux[15:0] = {bcast_addr, given_addr};
		end
	end

	// read data is registered at the end of the address phase
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hrdata <= '0;
		end else if (ce && hready && hsel && (htrans == HTRANS_NSEQ) && !hwrite) begin
			hrdata <= rd_mux;
		end
	end

	// configuration registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			baud_doubler       <= 1'b0;
			frame_error_select <= 1'b0;
			timer_mode         <= '0;
			timer_high_reload  <= '0;
			reload16           <= '0;
			given_addr         <= '0;
			bcast_addr         <= '0;
		end else if (wr_en) begin
			if (req.addr == OFF_PWR) begin
				baud_doubler       <= hwdata[PWR_DBL_BIT];
				frame_error_select <= hwdata[PWR_FSE_BIT];
			end else if (req.addr == OFF_TIMER_MODE_REGISTER) begin
				timer_mode <= hwdata[7:4];
			end else if (req.addr == OFF_RLD8) begin
				timer_high_reload <= hwdata[7:0];
			end else if (req.addr == OFF_RLD16) begin
				reload16 <= hwdata[15:0];
			end else if (req.addr == OFF_ADDR) begin
				given_addr <= hwdata[7:0];
				bcast_addr <= hwdata[15:8];
			end
		end
	end

	// control register: hardware sets are written last so they win
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			serial_control          <= sps_serial_control_t'(SERIAL_CONTROL_RESET);
			framing_error <= 1'b0;
		end else if (ce) begin
			if (wr_en && (req.addr == OFF_SCTRL)) begin
				// top bit goes to mode or error clear
				serial_control <= sps_serial_control_t'({frame_error_select ? serial_control.mode_bit_high : hwdata[7],
					hwdata[6:0]});
				if (frame_error_select && !hwdata[7]) begin
					framing_error <= 1'b0;
				end
			end
			if (ti_set_q) begin
				serial_control.transmit_flag <= 1'b1;
			end
			if (ri_set_q) begin
				serial_control.receive_flag <= 1'b1;
			end
			if (rb8_load_q) begin
				serial_control.received_ninth_bit <= rb8_val_q;
			end
			if (fe_set_q) begin
				framing_error <= 1'b1;
			end
		end
	end

	// mode select from the two mode bits
	assign mode = {serial_control.mode_bit_high, serial_control.mode_bit_low};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			t1cnt <= '0;
		end else if (ce) begin
			if (timer_mode[1:0] == T1_MODE_8) begin
				t1cnt <= {8'h00, (t1cnt[7:0] == T1_MAX8) ? timer_high_reload : t1cnt[7:0] + 8'h01};
			end else if (wr_en && (req.addr == OFF_RLD16)) begin
				// new reload restarts the count, so the first period is exact
				t1cnt <= hwdata[15:0];
			end else if (timer_mode[1:0] == T1_MODE_16) begin
				t1cnt <= (t1cnt == T1_MAX16) ? reload16 : t1cnt + 16'h0001;
			end
		end
	end
	assign t1_ovf = ((timer_mode[1:0] == T1_MODE_8) && (t1cnt[7:0] == T1_MAX8))
		|| ((timer_mode[1:0] == T1_MODE_16) && (t1cnt == T1_MAX16));

	// halving stages for the sixteen-times sample tick
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			osc_half <= 1'b0;
			ovf_half <= 1'b0;
		end else if (ce) begin
			osc_half <= !osc_half;
			if (t1_ovf) begin
				ovf_half <= !ovf_half;
			end
		end
	end

	// sample tick is sixteen per bit
	always_comb begin
		if (mode == MODE2) begin
			tick16 = baud_doubler | osc_half;
		end else begin
			tick16 = t1_ovf & (baud_doubler | ovf_half);
		end
	end

	// transmit bit-time divider, free running
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_div <= '0;
		end else if (ce && tick16) begin
			tx_div <= tx_div + 4'h1;
		end
	end
	assign bit_tick = tick16 && (tx_div == DIV_LAST);

	// mode 0 shift clock phase toggles every oscillator clock
	assign m0_busy = (mode == MODE0) && ((tx_st == TX_SEND) || (rx_st == RX_SHIFT0));
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ph <= 1'b0;
		end else if (ce) begin
			ph <= m0_busy ? !ph : 1'b0;
		end
	end

	assign tx_stop = mode[1] ? IDX_STOP23 : IDX_STOP1;

	// transmitter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_st    <= TX_IDLE;
			tx_sh    <= '0;
			tx_idx   <= '0;
			tx_cnt   <= '0;
			ti_set_q <= 1'b0;
		end else if (ce) begin
			ti_set_q <= 1'b0;
			case (tx_st)
				TX_IDLE: begin
					if (wr_buf) begin
						// marker or ninth bit above the byte
						tx_sh  <= {mode[1] ? serial_control.transmit_ninth_bit : 1'b1, hwdata[7:0]};
						tx_idx <= '0;
						tx_cnt <= '0;
						tx_st  <= TX_WAIT;
					end
				end
				TX_WAIT: begin
					if (mode == MODE0) begin
						if (tx_cnt == 4'(MC_DELAY - 1)) begin
							tx_st <= TX_SEND;
						end else begin
							tx_cnt <= tx_cnt + 4'h1;
						end
					end else if (bit_tick) begin
						tx_st <= TX_SEND;
					end
				end
				TX_SEND: begin
					if (mode == MODE0) begin
						if (ph) begin
							// shift right, zeros from the left, stop at marker
							tx_sh <= {1'b0, tx_sh[8:1]};
							if (tx_sh[8:1] == TX0_MARK) begin
								tx_st    <= TX_IDLE;
								ti_set_q <= 1'b1;
							end
						end
					end else if (bit_tick) begin
						if (tx_idx == tx_stop) begin
							tx_st <= TX_IDLE;
						end else begin
							tx_idx <= tx_idx + 4'h1;
							if (tx_idx != 4'h0) begin
								tx_sh <= {1'b0, tx_sh[8:1]};
							end
							// flag at start of stop bit
							if (tx_idx + 4'h1 == tx_stop) begin
								ti_set_q <= 1'b1;
							end
						end
					end
				end
				default: tx_st <= TX_IDLE;
			endcase
		end
	end

	// asynchronous line: start 0, data, ninth, stop 1
	assign tx_line = (tx_idx == 4'h0) ? 1'b0 : (tx_idx == tx_stop) ? 1'b1 : tx_sh[0];

	assign port_line_data_oe   = (mode == MODE0) && (tx_st == TX_SEND);
	assign port_line_data_out  = tx_sh[0];
	assign port_line_clock_out = m0_busy ? ph : ((tx_st == TX_SEND) ? tx_line : 1'b1);

	// asynchronous bit vote and address check
	assign maj     = (vote[0] & vote[1]) | (vote[0] & rxd) | (vote[1] & rxd);
	assign addr_ok = (rx_sh == given_addr) || (rx_sh == bcast_addr);

	// receiver
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_st      <= RX_IDLE;
			rx_sh      <= '0;
			rx_bit     <= 1'b1;
			rx_skip    <= 1'b0;
			rx_div     <= '0;
			rx_idx     <= '0;
			vote       <= '0;
			rx_ninth   <= 1'b0;
			rbuf       <= '0;
			ri_set_q   <= 1'b0;
			fe_set_q   <= 1'b0;
			rb8_load_q <= 1'b0;
			rb8_val_q  <= 1'b0;
		end else if (ce) begin
			ri_set_q   <= 1'b0;
			fe_set_q   <= 1'b0;
			rb8_load_q <= 1'b0;
			if (!serial_control.receive_enable) begin
				rx_st <= RX_IDLE;
			end else begin
				case (rx_st)
					RX_IDLE: begin
						// mode 0 start with flag clear
						if ((mode == MODE0) && !serial_control.receive_flag && !ri_set_q
							&& (tx_st == TX_IDLE) && !wr_buf) begin
							rx_sh <= RX0_PRELOAD;
							rx_st <= RX_LOAD0;
						end else if ((mode != MODE0) && rxd_prev && !rxd) begin
							// start bit edge resets the divider
							rx_div <= '0;
							rx_idx <= '0;
							rx_sh  <= '1;
							rx_st  <= RX_ASYNC;
						end
					end
					RX_LOAD0: begin
						rx_skip <= 1'b1;
						rx_st   <= RX_SHIFT0;
					end
					RX_SHIFT0: begin
						// sample on rising edge, shift left on falling edge
						if (!ph) begin
							rx_bit <= rxd;
						end else if (rx_skip) begin
							rx_skip <= 1'b0;
						end else begin
							rx_sh <= {rx_sh[6:0], rx_bit};
							// preloaded zero at the left ends reception
							if (!rx_sh[7]) begin
								rbuf     <= rev8({rx_sh[6:0], rx_bit});
								ri_set_q <= 1'b1;
								rx_st    <= RX_IDLE;
							end
						end
					end
					RX_ASYNC: begin
						if (tick16) begin
							rx_div <= rx_div + 4'h1;
							if ((rx_div == SMP_A) || (rx_div == SMP_B)) begin
								vote <= {vote[0], rxd};
							end
							if (rx_div == SMP_C) begin
								rx_idx <= rx_idx + 4'h1;
								if (rx_idx == 4'h0) begin
									if (maj) begin
										rx_st <= RX_IDLE;
									end
								end else if (rx_idx < IDX_NINTH) begin
									rx_sh <= {maj, rx_sh[7:1]};
								end else if (mode[1] && (rx_idx == IDX_NINTH)) begin
									rx_ninth <= maj;
								end else begin
									// decision halfway through the stop bit
									rx_st    <= RX_IDLE;
									fe_set_q <= !maj;
									if (mode == MODE1) begin
										// filter on stop bit and address
										if (!serial_control.receive_flag && (!serial_control.address_filter_enable
											|| (maj && addr_ok))) begin
											rbuf       <= rx_sh;
											ri_set_q   <= 1'b1;
											// stop bit kept only without filter
											rb8_load_q <= !serial_control.address_filter_enable;
											rb8_val_q  <= maj;
										end
									end else if (!serial_control.receive_flag && (!serial_control.address_filter_enable
										|| (rx_ninth && addr_ok))) begin
										// filter on ninth bit and address
										rbuf       <= rx_sh;
										ri_set_q   <= 1'b1;
										rb8_load_q <= 1'b1;
										rb8_val_q  <= rx_ninth;
									end
								end
							end
						end
					end
					default: rx_st <= RX_IDLE;
				endcase
			end
		end
	end

	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// checks on the logic above
	mode0_clock_rate_a: assert property (ce && $past(ce) && m0_busy && $past(m0_busy)
		|-> ph != $past(ph)) else $error("mode 0 clock does not toggle every clock");
	tx0_load_marker_a: assert property (ce && wr_buf && (tx_st == TX_IDLE) && (mode == MODE0)
		|=> tx_sh == {1'b1, $past(hwdata[7:0])} ##1 (!ce || tx_st == TX_SEND))
		else $error("mode 0 load or drive delay wrong");
	tx0_shift_right_a: assert property (ce && (tx_st == TX_SEND) && (mode == MODE0) && ph
		|=> tx_sh == {1'b0, $past(tx_sh[8:1])}) else $error("mode 0 transmit shift wrong");
	ti_set_after_a: assert property (ce && ti_set_q |=> serial_control.transmit_flag)
		else $error("transmit flag not set");
	rx0_preload_a: assert property (rx_st == RX_LOAD0
		|-> rx_sh == RX0_PRELOAD ##1 (!ce || !serial_control.receive_enable || rx_st == RX_SHIFT0))
		else $error("mode 0 receive preload wrong");
	rx_needs_enable_a: assert property ($past(ce) && rx_st != RX_IDLE
		&& $past(rx_st) == RX_IDLE |-> $past(serial_control.receive_enable))
		else $error("reception started without enable");
	mode2_fast_tick_a: assert property ((mode == MODE2) && baud_doubler |-> tick16)
		else $error("mode 2 doubled rate wrong");
	mode2_slow_tick_a: assert property (ce && (mode == MODE2) && !baud_doubler && tick16
		&& $past(mode) == MODE2 |=> !tick16 || $changed(baud_doubler))
		else $error("mode 2 base rate wrong");
	t1_reload8_a: assert property (ce && (timer_mode[1:0] == T1_MODE_8)
		&& (t1cnt[7:0] == T1_MAX8) |=> t1cnt[7:0] == $past(timer_high_reload))
		else $error("eight-bit reload wrong");
	addr_filter_a: assert property (ri_set_q && mode[1] && serial_control.address_filter_enable
		|-> rx_ninth && ((rbuf == given_addr) || (rbuf == bcast_addr)))
		else $error("filtered frame raised receive flag");
	start_bit_low_a: assert property ((tx_st == TX_SEND) && (mode != MODE0)
		&& (tx_idx == 4'h0) |-> !port_line_clock_out) else $error("start bit not low");
endmodule

/* sps_remote.sv */
`timescale 1ns/1ps
// remote shift register on the mode 0 pins, and a line echo for the framed modes
module sps_remote (
	input  logic shift_clk,
	input  logic dev_data,
	input  logic dev_oe,
	input  logic loop,
	output logic line
);
	logic [7:0] tx_byte = 8'h00;
	logic [7:0] got     = 8'h00;
	logic       drv     = 1'b1;
	int         idx     = 0;
	int         nbits   = 0;
	int         nrise   = 0;
	realtime    t_rise  = 0;
	realtime    t_fall  = 0;
	realtime    per     = 0;
	realtime    wmax    = 0;

	// data pin level from the device enable, the clock echo while loop is set, and our own drive
	assign line = dev_oe ? dev_data : (loop ? shift_clk : drv);

	// prepare the next byte to send and clear idx, nbits and wmax
	task automatic arm(input logic [7:0] b);
		tx_byte = b;
		idx = 0;
		nbits = 0;
		wmax = 0;
	endtask

	always @(posedge shift_clk) begin
		nrise++;
		if (loop && ($realtime - t_fall) > wmax)
			wmax = $realtime - t_fall;
		if (!loop && dev_oe)
			per = $realtime - t_rise;
		t_rise = $realtime;
		#1;
		if (dev_oe) begin
			got = {dev_data, got[7:1]};
			nbits++;
		end
	end

	always @(negedge shift_clk) begin
		t_fall = $realtime;
		#1;
		if (!dev_oe && !loop) begin
			// past the byte the line keeps changing, never holding a stale bit
			drv = (idx < 8) ? tx_byte[idx[2:0]] : ~drv;
			idx++;
		end
	end
endmodule

/* test_serial_port_modes_baud_shift.sv */
`timescale 1ns/1ps
// testbench: register access, mode 0 shifting and framed loopback of the serial port
module test_serial_port_modes_baud_shift;
	import sps_pkg::*;
	logic        clk;
	logic        rst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic        line;
	logic        dout;
	logic        doe;
	logic        sclk;
	logic        loop;
	int          errors = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          n;
	logic [7:0]  t_sc [4] = '{8'h98, 8'h98, 8'hD0, 8'h50};
	logic [7:0]  t_pw [4] = '{8'h80, 8'h00, 8'h00, 8'h80};
	logic [7:0]  t_tm [4] = '{8'h00, 8'h00, 8'h10, 8'h20};
	logic [7:0]  t_ex [4] = '{8'h9F, 8'h9F, 8'hD3, 8'h57};
	int          t_ns [4] = '{800, 1600, 6400, 1600};

	sps_serial_port i_dut (
		.clk                 (clk),
		.rst_n               (rst_n),
		.ce                  (1'b1),
		.hsel                (hsel),
		.haddr               (haddr),
		.htrans              (htrans),
		.hwrite              (hwrite),
		.hsize               (hsize),
		.hwdata              (hwdata),
		.hready              (hready),
		.hreadyout           (hready),
		.hresp               (),
		.hrdata              (hrdata),
		.port_line_data_in   (line),
		.port_line_data_out  (dout),
		.port_line_data_oe   (doe),
		.port_line_clock_out (sclk)
	);

	sps_remote i_remote (
		.shift_clk (sclk),
		.dev_data  (dout),
		.dev_oe    (doe),
		.loop      (loop),
		.line      (line)
	);

	// clock source
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// verdict and end of run
	task automatic results();
		if (errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// compare one value and count it
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one single transfer: address phase, then data phase
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= HTRANS_NSEQ;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	// register helpers
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(rd, e);
	endtask

	// poll the control register until a flag is set, bounded
	task automatic wait_bit(input int b);
		int i;
		for (i = 0; i < 3000; i++) begin
			bus(OFF_SCTRL, 1'b0, 32'h0);
			if (rd[b] === 1'b1)
				break;
		end
		chk(rd[b], 1);
	endtask

	// one framed byte through the line echo, under table entry k
	task automatic run(input int k);
		wr(OFF_PWR, {24'h0, t_pw[k]});
		wr(8'h0C, {24'h0, t_tm[k]}); // timer mode, no timer interrupt used
		wr(OFF_SCTRL, {24'h0, t_sc[k]});
		i_remote.arm(8'h00);
		wr(OFF_BUF, 32'h5A);
		wait_bit(0);
		rd_chk(OFF_SCTRL, {24'h0, t_ex[k]});
		rd_chk(OFF_BUF, 32'h5A);
		chk(int'(i_remote.wmax), t_ns[k]);
		// let the stop bit finish before the next frame is set up
		repeat (160) @(posedge clk);
	endtask

	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			results();
		end
	end

	// main sequence
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		loop = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd_chk(OFF_SCTRL, 32'h0);
		rd_chk(OFF_PWR, 32'h0);
		rd_chk(8'h1C, 32'h0);
		chk({doe, sclk}, 2'h1);
		// mode 0 send, address filter kept off
		i_remote.arm(8'h00);
		wr(OFF_BUF, 32'hA5);
		wait_bit(1);
		chk(i_remote.got, 8'hA5);
		chk(i_remote.nbits, 8);
		chk(int'(i_remote.per), 50);
		wr(OFF_SCTRL, 32'h0);
		// mode 0 receive
		i_remote.arm(8'h3C);
		wr(OFF_SCTRL, 32'h10);
		wait_bit(0);
		rd_chk(OFF_BUF, 32'h3C);
		wr(OFF_SCTRL, 32'h0);
		n = i_remote.nrise;
		repeat (100) @(posedge clk);
		chk(i_remote.nrise, n);
		// framed modes through the line echo
		loop <= 1'b1;
		wr(OFF_RLD8, 32'hFE);
		wr(OFF_RLD16, 32'hFFFC);
		for (int k = 0; k < 4; k++)
			run(k);
		// address frame filter drops a byte whose ninth bit is 0
		wr(OFF_ADDR, 32'h5A);
		wr(OFF_PWR, 32'h80);
		wr(OFF_SCTRL, 32'hB0);
		wr(OFF_BUF, 32'h5A);
		wait_bit(1);
		repeat (400) @(posedge clk);
		rd_chk(OFF_SCTRL, 32'hB2);
		// the same byte as an address frame matches the given address
		wr(OFF_SCTRL, 32'hB8);
		wr(OFF_BUF, 32'h5A);
		wait_bit(0);
		rd_chk(OFF_SCTRL, 32'hBF);
		rd_chk(OFF_BUF, 32'h5A);
		results();
	end
endmodule
